/* File: core/ocb_pkg.sv */
// Purpose: constants and types for the operational controls register bank
// Assumes: byte address on the bus is four times the register index
// Notes:   only the low byte of each word is populated
package ocb_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned NUM_REF = 4;
    localparam int unsigned NUM_ANALOG_OUTPUT_PLL = 2;

    // register indices
    localparam logic [ADDR_W-1:0] IDX_GLOBAL_CONTROL        = 16'h2000;
    localparam logic [ADDR_W-1:0] IDX_REFERENCE_POWERDOWN   = 16'h2001;
    localparam logic [ADDR_W-1:0] IDX_REFERENCE_TIMEOUT     = 16'h2002;
    localparam logic [ADDR_W-1:0] IDX_REFERENCE_FAULT_FORCE = 16'h2003;
    localparam logic [ADDR_W-1:0] IDX_REFERENCE_BYPASS      = 16'h2004;
    localparam logic [ADDR_W-1:0] IDX_INTERRUPT_CLEAR       = 16'h2005;
    localparam logic [ADDR_W-1:0] IDX_REGISTER_UPDATE       = 16'h2006;

    // word index inside the byte address
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W   = ADDR_W - IDX_LSB;

    // writable bits per register; the rest are reserved and read zero
    localparam logic [REG_W-1:0] MASK_GLOBAL_CONTROL = 8'h0f;
    localparam logic [REG_W-1:0] MASK_REFERENCE      = 8'h0f;
    localparam logic [REG_W-1:0] MASK_INTERRUPT      = 8'h8f;

    localparam logic [REG_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [REG_W-1:0] UPDATE_CMD  = 8'h01;

    // global control field positions
    localparam int unsigned BIT_CHIP_SLEEP   = 0;
    localparam int unsigned BIT_CAL_ALL      = 1;
    localparam int unsigned BIT_CAL_SYSTEM   = 2;
    localparam int unsigned BIT_DIVIDER_HOLD = 3;

    // reference bit order: a, a_complement, b, b_complement
    localparam int unsigned REF_LSB = 0;

    typedef struct packed {
        logic [REG_W-1:0] interrupt_clear;
        logic [REG_W-1:0] reference_monitor_bypass;
        logic [REG_W-1:0] reference_fault_force;
        logic [REG_W-1:0] reference_validation_timeout;
        logic [REG_W-1:0] reference_powerdown;
        logic [REG_W-1:0] global_control;
    } ocb_bank_t;

    localparam ocb_bank_t BANK_RESET = '{
        interrupt_clear:              RESET_VALUE,
        reference_monitor_bypass:     RESET_VALUE,
        reference_fault_force:        RESET_VALUE,
        reference_validation_timeout: RESET_VALUE,
        reference_powerdown:          RESET_VALUE,
        global_control:               RESET_VALUE
    };

endpackage

/* File: core/ocb_rise_detect.sv */
// Purpose: per-bit rising edge detector, one-cycle pulse per edge
// Assumes: input levels are on the same clock
// Notes:   history resets to zero, so a level high out of reset fires once
`timescale 1ns/1ps
`default_nettype none
module ocb_rise_detect #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             CLOCK_I,
    input  wire logic             RST_B_I,
    input  wire logic [WIDTH-1:0] LEVEL_I,
    output logic      [WIDTH-1:0] RISE_O
);

    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] rise_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    last_reg[g] <= 1'b0;
                    rise_reg[g] <= 1'b0;
                end else begin
                    last_reg[g] <= LEVEL_I[g];
                    rise_reg[g] <= LEVEL_I[g] & ~last_reg[g];
                end
            end
        end
    endgenerate

    assign RISE_O = rise_reg;

endmodule // ocb_rise_detect
`default_nettype wire

/* File: core/ocb_operational_controls.sv */
// Purpose: operational controls register bank behind an Avalon-MM slave
// Assumes: reference status inputs and the bus share CLOCK_I
// Notes:   writes land in a shadow bank; an update command commits them
//
// Behaviour
// R1: divider hold bit keeps all dividers reset
// R2: software syncs dividers: hold, update, release, update
// R3: system pll calibrates on rising calibrate bit
// R4: system trigger is OR of both calibrate bits
// R5: rising calibrate-all calibrates every pll; the system pll is skipped if its own calibrate bit is already set
// R6: software clears calibrate bits after setting them
// R7: software calibrates all plls at initial programming
// R8: sleep bit puts whole chip in low power
// R9: bus stays usable while chip sleeps
// R10: bit 3 powers down b complement receiver
// R11: bits 2..0 power down b, a complement, a
// R12: committed timeout bit validates counting unfaulted reference
// R13: reserved bits read zero; registers reset zero
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ocb_operational_controls #(
    parameter int unsigned NUM_REF  = ocb_pkg::NUM_REF,
    parameter int unsigned NUM_ANALOG_OUTPUT_PLL = ocb_pkg::NUM_ANALOG_OUTPUT_PLL
) (
    input  wire logic                        CLOCK_I,
    input  wire logic                        RST_B_I,
    // avalon-mm slave
    input  wire logic [ocb_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
    input  wire logic                        AVS_READ_I,
    input  wire logic                        AVS_WRITE_I,
    input  wire logic [ocb_pkg::DATA_W-1:0]  AVS_WRITEDATA_I,
    input  wire logic [3:0]                  AVS_BYTEENABLE_I,
    output logic      [ocb_pkg::DATA_W-1:0]  AVS_READDATA_O,
    output logic                             AVS_WAITREQUEST_O,
    // reference monitor status
    input  wire logic [NUM_REF-1:0]          REF_UNFAULTED_I,
    input  wire logic [NUM_REF-1:0]          REF_VALIDATION_COUNTING_I,
    // controls toward the rest of the chip
    output logic                             DIVIDER_HOLD_O,
    output logic                             CHIP_SLEEP_O,
    output logic                             SYSTEM_CLOCK_PLL_CAL_O,
    output logic      [NUM_ANALOG_OUTPUT_PLL-1:0]         ANALOG_OUTPUT_PLL_CAL_O,
    output logic      [NUM_REF-1:0]          REF_POWERDOWN_O,
    output logic      [NUM_REF-1:0]          REF_FAULT_FORCE_O,
    output logic      [NUM_REF-1:0]          REF_MONITOR_BYPASS_O,
    output logic      [NUM_REF-1:0]          REF_VALIDATE_O,
    output logic      [ocb_pkg::REG_W-1:0]   IRQ_CLEAR_O
);

    localparam int unsigned RW = ocb_pkg::REG_W;
    localparam int unsigned RL = ocb_pkg::REF_LSB;

    typedef enum logic [1:0] {
        OCB_IDLE,
        OCB_ACK
    } ocb_bus_state_t;

    ocb_bus_state_t                      bus_state_reg;
    ocb_bus_state_t                      bus_state_next;

    ocb_pkg::ocb_bank_t                  shadow_reg;
    ocb_pkg::ocb_bank_t                  active_reg;

    logic [ocb_pkg::DATA_W-1:0]          readdata_reg;
    logic [ocb_pkg::DATA_W-1:0]          readdata_next;
    logic [ocb_pkg::IDX_W-1:0]           word_index;
    logic                                request;
    logic                                write_commit;
    logic                                low_byte_en;
    logic [RW-1:0]                       wdata_byte;
    logic                                commit_update;

    logic                                cal_system_level;
    logic [1:0]                          cal_levels;
    logic [1:0]                          cal_rise;

    logic [NUM_REF-1:0]                  timeout_committed;
    logic [NUM_REF-1:0]                  validate_reg;

    assign request     = AVS_READ_I | AVS_WRITE_I;
    assign word_index  = AVS_ADDRESS_I[ocb_pkg::ADDR_W-1:ocb_pkg::IDX_LSB];
    assign low_byte_en = AVS_BYTEENABLE_I[0];
    assign wdata_byte  = AVS_WRITEDATA_I[RW-1:0];

    // one wait state: the answer comes on the second cycle of a request
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            OCB_IDLE: begin
                if (request) begin
                    bus_state_next = OCB_ACK;
                end
            end
            OCB_ACK: begin
                bus_state_next = OCB_IDLE;
            end
            default: begin
                bus_state_next = OCB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bus_state_reg <= OCB_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // bus is never gated by the sleep bit, so software can wake the chip
    assign AVS_WAITREQUEST_O = request & (bus_state_reg != OCB_ACK); // R9

    assign write_commit = AVS_WRITE_I & (bus_state_reg == OCB_ACK) & low_byte_en;

    assign commit_update = write_commit
                         & (word_index == ocb_pkg::IDX_REGISTER_UPDATE[ocb_pkg::IDX_W-1:0])
                         & ((wdata_byte & ocb_pkg::UPDATE_CMD) != ocb_pkg::RESET_VALUE);

    function automatic logic idx_is(input logic [ocb_pkg::IDX_W-1:0] idx,
                                    input logic [ocb_pkg::ADDR_W-1:0] reg_idx);
        idx_is = (idx == reg_idx[ocb_pkg::IDX_W-1:0]);
    endfunction

    // read data is captured in the first cycle and stands through the ack
    always_comb begin
        readdata_next = '0;
        if (idx_is(word_index, ocb_pkg::IDX_GLOBAL_CONTROL)) begin
            readdata_next[RW-1:0] = shadow_reg.global_control;
        end else if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_POWERDOWN)) begin
            readdata_next[RW-1:0] = shadow_reg.reference_powerdown;
        end else if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_TIMEOUT)) begin
            readdata_next[RW-1:0] = shadow_reg.reference_validation_timeout;
        end else if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_FAULT_FORCE)) begin
            readdata_next[RW-1:0] = shadow_reg.reference_fault_force;
        end else if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_BYPASS)) begin
            readdata_next[RW-1:0] = shadow_reg.reference_monitor_bypass;
        end else if (idx_is(word_index, ocb_pkg::IDX_INTERRUPT_CLEAR)) begin
            readdata_next[RW-1:0] = shadow_reg.interrupt_clear;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            readdata_reg <= '0;
        end else if (AVS_READ_I && bus_state_reg == OCB_IDLE) begin
            readdata_reg <= readdata_next;
        end
    end

    assign AVS_READDATA_O = readdata_reg;

    // shadow bank: reserved bits are masked on the way in
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            shadow_reg <= ocb_pkg::BANK_RESET; // R13
        end else begin
            if (commit_update) begin
                // timeout bits clear themselves once committed
                shadow_reg.reference_validation_timeout <= ocb_pkg::RESET_VALUE; // R12
            end
            if (write_commit) begin
                if (idx_is(word_index, ocb_pkg::IDX_GLOBAL_CONTROL)) begin
                    shadow_reg.global_control <= wdata_byte & ocb_pkg::MASK_GLOBAL_CONTROL; // R13
                end
                if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_POWERDOWN)) begin
                    shadow_reg.reference_powerdown <= wdata_byte & ocb_pkg::MASK_REFERENCE; // R13
                end
                if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_TIMEOUT)) begin
                    shadow_reg.reference_validation_timeout <=
                        wdata_byte & ocb_pkg::MASK_REFERENCE; // R13
                end
                if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_FAULT_FORCE)) begin
                    shadow_reg.reference_fault_force <= wdata_byte & ocb_pkg::MASK_REFERENCE; // R13
                end
                if (idx_is(word_index, ocb_pkg::IDX_REFERENCE_BYPASS)) begin
                    shadow_reg.reference_monitor_bypass <=
                        wdata_byte & ocb_pkg::MASK_REFERENCE; // R13
                end
                if (idx_is(word_index, ocb_pkg::IDX_INTERRUPT_CLEAR)) begin
                    shadow_reg.interrupt_clear <= wdata_byte & ocb_pkg::MASK_INTERRUPT; // R13
                end
            end
        end
    end

    // active bank follows the shadow only on an update command
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            active_reg <= ocb_pkg::BANK_RESET; // R13
        end else if (commit_update) begin
            active_reg <= shadow_reg;
            // timeout acts once, it never stays armed in the active bank
            active_reg.reference_validation_timeout <= ocb_pkg::RESET_VALUE; // R12
        end
    end

    assign timeout_committed = {NUM_REF{commit_update}}
                             & shadow_reg.reference_validation_timeout[RL +: NUM_REF];

    // validation only while the reference is clean and its timer runs
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            validate_reg <= '0;
        end else begin
            validate_reg <= timeout_committed
                          & REF_UNFAULTED_I
                          & REF_VALIDATION_COUNTING_I; // R12
        end
    end

    assign REF_VALIDATE_O = validate_reg;

    // a held calibrate-all masks the system bit, so no second edge appears
    assign cal_system_level = active_reg.global_control[ocb_pkg::BIT_CAL_SYSTEM]
                            | active_reg.global_control[ocb_pkg::BIT_CAL_ALL]; // R4

    assign cal_levels = {active_reg.global_control[ocb_pkg::BIT_CAL_ALL], cal_system_level};

    ocb_rise_detect #(
        .WIDTH (2)
    ) u_cal_rise (
        .CLOCK_I (CLOCK_I),
        .RST_B_I (RST_B_I),
        .LEVEL_I (cal_levels),
        .RISE_O  (cal_rise)
    );

    // only a 0 to 1 change calibrates; a steady 1 does nothing more
    assign SYSTEM_CLOCK_PLL_CAL_O  = cal_rise[0]; // R3
    assign ANALOG_OUTPUT_PLL_CAL_O = {NUM_ANALOG_OUTPUT_PLL{cal_rise[1]}}; // R5

    assign DIVIDER_HOLD_O = active_reg.global_control[ocb_pkg::BIT_DIVIDER_HOLD]; // R1
    assign CHIP_SLEEP_O   = active_reg.global_control[ocb_pkg::BIT_CHIP_SLEEP]; // R8

    // bit order a, a complement, b, b complement from bit 0 up
    assign REF_POWERDOWN_O      = active_reg.reference_powerdown[RL +: NUM_REF]; // R10 R11
    assign REF_FAULT_FORCE_O    = active_reg.reference_fault_force[RL +: NUM_REF];
    assign REF_MONITOR_BYPASS_O = active_reg.reference_monitor_bypass[RL +: NUM_REF];
    assign IRQ_CLEAR_O          = active_reg.interrupt_clear;

endmodule // ocb_operational_controls
`default_nettype wire

/* File: verification/ocb_operational_controls_sva.sv */
// Purpose: port assertions for the operational controls bank
// Assumes: master holds each request until waitrequest is low
// Notes:   commit is an accepted write of bit0 to the update index
`timescale 1ns/1ps
`default_nettype none
module ocb_operational_controls_sva #(
    parameter int unsigned NUM_REF  = 4,
    parameter int unsigned NUM_ANALOG_OUTPUT_PLL = 2
) (
    input wire logic                       CLOCK_I,
    input wire logic                       RST_B_I,
    input wire logic [ocb_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic                       AVS_READ_I,
    input wire logic                       AVS_WRITE_I,
    input wire logic [ocb_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0]                 AVS_BYTEENABLE_I,
    input wire logic [ocb_pkg::DATA_W-1:0] AVS_READDATA_O,
    input wire logic                       AVS_WAITREQUEST_O,
    input wire logic [NUM_REF-1:0]         REF_UNFAULTED_I,
    input wire logic [NUM_REF-1:0]         REF_VALIDATION_COUNTING_I,
    input wire logic                       DIVIDER_HOLD_O,
    input wire logic                       CHIP_SLEEP_O,
    input wire logic                       SYSTEM_CLOCK_PLL_CAL_O,
    input wire logic [NUM_ANALOG_OUTPUT_PLL-1:0]        ANALOG_OUTPUT_PLL_CAL_O,
    input wire logic [NUM_REF-1:0]         REF_POWERDOWN_O,
    input wire logic [NUM_REF-1:0]         REF_FAULT_FORCE_O,
    input wire logic [NUM_REF-1:0]         REF_MONITOR_BYPASS_O,
    input wire logic [NUM_REF-1:0]         REF_VALIDATE_O,
    input wire logic [ocb_pkg::REG_W-1:0]  IRQ_CLEAR_O
);
    logic commit;
    // only an accepted write counts, so a stalled write cannot commit early
    assign commit = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[0]
        && (AVS_ADDRESS_I[15:2] == ocb_pkg::IDX_REGISTER_UPDATE[13:0]);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    AST_WAIT_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest longer than one cycle");
    AST_IDLE_READY: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
        else $error("waitrequest high while idle");
    AST_HOLD_COMMIT: assert property ($changed(DIVIDER_HOLD_O) |-> $past(commit))
        else $error("divider hold moved without commit");
    AST_SLEEP_COMMIT: assert property ($changed(CHIP_SLEEP_O) |-> $past(commit))
        else $error("sleep moved without commit");
    AST_PWDN_COMMIT: assert property ($changed(REF_POWERDOWN_O) |-> $past(commit))
        else $error("receiver power-down moved without commit");
    AST_SYS_CAL: assert property (SYSTEM_CLOCK_PLL_CAL_O |-> $past(commit, 2) ##1 !SYSTEM_CLOCK_PLL_CAL_O)
        else $error("system calibration pulse bad");
    AST_ANALOG_OUTPUT_PLL_PAIR: assert property (ANALOG_OUTPUT_PLL_CAL_O == {NUM_ANALOG_OUTPUT_PLL{ANALOG_OUTPUT_PLL_CAL_O[0]}})
        else $error("analog calibrations differ");
    AST_ANALOG_OUTPUT_PLL_CAL: assert property (ANALOG_OUTPUT_PLL_CAL_O[0] |-> $past(commit, 2) ##1 !ANALOG_OUTPUT_PLL_CAL_O[0])
        else $error("analog calibration pulse bad");
    AST_VAL_CAUSE: assert property (|REF_VALIDATE_O |-> $past(commit) && ((REF_VALIDATE_O
        & ~($past(REF_UNFAULTED_I) & $past(REF_VALIDATION_COUNTING_I))) == '0))
        else $error("validate without cause");
    AST_VAL_PULSE: assert property (|REF_VALIDATE_O |=> REF_VALIDATE_O == '0)
        else $error("validate longer than one cycle");
endmodule // ocb_operational_controls_sva
bind ocb_operational_controls ocb_operational_controls_sva #(.NUM_REF(NUM_REF), .NUM_ANALOG_OUTPUT_PLL(NUM_ANALOG_OUTPUT_PLL)) u_sva (
    .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .REF_UNFAULTED_I(REF_UNFAULTED_I), .REF_VALIDATION_COUNTING_I(REF_VALIDATION_COUNTING_I),
    .DIVIDER_HOLD_O(DIVIDER_HOLD_O), .CHIP_SLEEP_O(CHIP_SLEEP_O),
    .SYSTEM_CLOCK_PLL_CAL_O(SYSTEM_CLOCK_PLL_CAL_O), .ANALOG_OUTPUT_PLL_CAL_O(ANALOG_OUTPUT_PLL_CAL_O),
    .REF_POWERDOWN_O(REF_POWERDOWN_O), .REF_FAULT_FORCE_O(REF_FAULT_FORCE_O),
    .REF_MONITOR_BYPASS_O(REF_MONITOR_BYPASS_O), .REF_VALIDATE_O(REF_VALIDATE_O), .IRQ_CLEAR_O(IRQ_CLEAR_O));
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for the operational controls bank
// Assumes: one wait state per access, commit via update index
// Notes:   pulses are counted by a monitor, checked after idle cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  be = 4'h1;
    logic [3:0]  unflt = 4'h0;
    logic [3:0]  cnting = 4'h0;
    logic [31:0] rdata, q;
    logic        waitreq, hold, sleep, sys_cal;
    logic [1:0]  analog_output_pll_cal;
    logic [3:0]  pwdn, fforce, bypass, valid;
    logic [3:0]  val_acc = 4'h0;
    logic [7:0]  irqc;
    logic [7:0]  mask [6] = '{ocb_pkg::MASK_GLOBAL_CONTROL, ocb_pkg::MASK_REFERENCE,
        ocb_pkg::MASK_REFERENCE, ocb_pkg::MASK_REFERENCE, ocb_pkg::MASK_REFERENCE, ocb_pkg::MASK_INTERRUPT};
    logic [7:0]  cal_seq [7] = '{8'h04, 8'h06, 8'h06, 8'h00, 8'h02, 8'h06, 8'h00};
    int          bad_count = 0;
    int          cmp_count = 0;
    int          sys_n = 0;
    int          analog_output_pll_n = 0;
    int          cycles = 0;

    always #4 clk = ~clk;

    ocb_operational_controls dut (.CLOCK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .REF_UNFAULTED_I(unflt),
        .REF_VALIDATION_COUNTING_I(cnting), .DIVIDER_HOLD_O(hold), .CHIP_SLEEP_O(sleep),
        .SYSTEM_CLOCK_PLL_CAL_O(sys_cal), .ANALOG_OUTPUT_PLL_CAL_O(analog_output_pll_cal), .REF_POWERDOWN_O(pwdn),
        .REF_FAULT_FORCE_O(fforce), .REF_MONITOR_BYPASS_O(bypass), .REF_VALIDATE_O(valid),
        .IRQ_CLEAR_O(irqc));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // pulses only stand one cycle, so they are tallied here at every edge
    always @(posedge clk) begin
        cycles++;
        if (sys_cal === 1'b1) sys_n++;
        if (analog_output_pll_cal === 2'b11) analog_output_pll_n++;
        if (valid !== 4'h0) val_acc = val_acc | valid;
        if (cycles == 3000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [2:0] off, input logic [7:0] d, input logic [3:0] en);
        @(posedge clk);
        addr  <= {ocb_pkg::IDX_GLOBAL_CONTROL[13:0] + 14'(off), 2'b00};
        wr_en <= w;
        rd_en <= ~w;
        wdata <= {24'h000000, d};
        be    <= en;
        // no local limit: only the bench timeout may end a stuck wait
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] off, input logic [7:0] d);
        bus(1'b1, off, d, 4'h1);
    endtask

    task automatic rd(input logic [2:0] off, input logic [7:0] exp);
        bus(1'b0, off, 8'h00, 4'h1);
        chk(q, {24'h000000, exp});
    endtask

    // idle cycles let the delayed calibration and validate pulses land
    task automatic commit();
        wr(3'd6, ocb_pkg::UPDATE_CMD);
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        for (int i = 1; i < 6; i++) wr(i[2:0], 8'hff);
        for (int i = 1; i < 6; i++) rd(i[2:0], mask[i]);
        bus(1'b1, 3'd1, 8'h00, 4'h0);
        rd(3'd1, 8'h0f);
        wr(3'd7, 8'hff);
        rd(3'd7, 8'h00);
        chk(32'(pwdn), 32'h0);
        unflt  <= 4'h5;
        cnting <= 4'h3;
        commit();
        chk(32'(pwdn), 32'hf);
        chk({fforce, bypass, irqc}, 32'hff8f);
        chk(32'(val_acc), 32'h1);
        rd(3'd2, 8'h00);
        unflt  <= 4'hf;
        cnting <= 4'h7;
        wr(3'd2, 8'h0e);
        commit();
        chk(32'(val_acc), 32'h7);
        wr(3'd0, 8'h08);
        chk(32'(hold), 32'h0);
        commit();
        chk(32'(hold), 32'h1);
        wr(3'd0, 8'h00);
        commit();
        chk(32'(hold), 32'h0);
        for (int i = 0; i < 7; i++) begin
            wr(3'd0, cal_seq[i]);
            commit();
        end
        chk(32'(sys_n), 32'h2);
        chk(32'(analog_output_pll_n), 32'h2);
        wr(3'd0, 8'h09);
        commit();
        chk({hold, sleep}, 32'h3);
        wr(3'd3, 8'h05);
        rd(3'd3, 8'h05);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk({hold, sleep, pwdn}, 32'h0);
        rst_b <= 1'b1;
        rd(3'd0, 8'h00);
        rd(3'd3, 8'h00);
        close_out();
    end
endmodule // tb
`default_nettype wire
